/* File: core/clbs_pkg.sv */
// shared constants, encodings and carrier types for the local bus strobe unit
package clbs_pkg;

    // clocks per bus T-state; the divider makes one tick per T-state
    localparam int TSTATE_CLKS = 2;

    // register byte offsets on the Avalon slave
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0C;
    localparam logic [4:0] REG_RDATA = 5'h10;
    localparam logic [4:0] REG_VECTOR = 5'h14;
    localparam logic [4:0] REG_HANDLER = 5'h18;

    // control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_MEM = 2;
    localparam int CTRL_BYTE = 3;
    localparam int CTRL_SEG_LSB = 4;
    localparam int CTRL_IE = 6;
    localparam int CTRL_INSTR_END = 7;

    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_IRQ = 1;
    localparam int ST_INTA = 2;
    localparam int ST_VEC_VALID = 3;
    localparam int ST_HOLD = 4;
    localparam int ST_TSTATE_LSB = 8;

    // values after reset
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [19:0] ADDR_RESET = 20'h00000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [7:0] VECTOR_RESET = 8'h00;

    // segment status codes, high bit then low bit
    localparam logic [1:0] SEG_ALT_DATA = 2'h0;
    localparam logic [1:0] SEG_STACK = 2'h1;
    localparam logic [1:0] SEG_CODE_NONE = 2'h2;
    localparam logic [1:0] SEG_DATA = 2'h3;

    // vector table: four bytes per entry, segment word two bytes past offset
    localparam int VEC_ENTRY_SHIFT = 2;
    localparam logic [19:0] VEC_SEG_STEP = 20'h00002;

    typedef enum logic [2:0] {
        TS_IDLE = 3'h0,
        TS_T1 = 3'h1,
        TS_T2 = 3'h2,
        TS_T3 = 3'h3,
        TS_WAIT = 3'h4,
        TS_T4 = 3'h5
    } clbs_tstate_t;

    typedef enum logic [2:0] {
        SQ_USER = 3'h0,
        SQ_INTA1 = 3'h1,
        SQ_INTA2 = 3'h2,
        SQ_VEC_OFF = 3'h3,
        SQ_VEC_SEG = 3'h4
    } clbs_stage_t;

    // one bus cycle as launched by the sequencer
    typedef struct packed {
        logic [19:0] addr;
        logic [15:0] wdata;
        logic read;
        logic mem;
        logic bhe_n;
        logic a0_n;
        logic [1:0] seg;
        logic inta;
    } clbs_cycle_t;

endpackage

/* File: core/clbs_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ns
module clbs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* File: core/clbs_bus_unit.sv */
// local bus cycle sequencer with status, byte-select, read strobe and interrupt entry
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
module clbs_bus_unit #(
    parameter int TSTATE_CLKS = clbs_pkg::TSTATE_CLKS
) (
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // local bus
    input wire logic [15:0] ad_in,
    output logic [15:0] ad_out,
    output logic ad_oe_n,
    output logic [1:0] addr_hi_status,
    output logic segment_status_hi,
    output logic segment_status_lo,
    output logic status_oe_n,
    output logic high_byte_enable_n,
    output logic low_byte_select_n,
    output logic read_n,
    output logic read_oe_n,
    output logic inta_n,
    output logic mem_io,
    output logic ale,
    input wire logic ready,
    input wire logic maskable_irq_in,
    input wire logic hold_req,
    output logic hold_ack
);
    localparam int DIV_W = (TSTATE_CLKS > 1) ? $clog2(TSTATE_CLKS) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TSTATE_CLKS - 1);

    logic [DIV_W-1:0] div_cnt;
    logic tick;
    clbs_pkg::clbs_tstate_t tstate;
    clbs_pkg::clbs_stage_t stage;
    clbs_pkg::clbs_cycle_t cur;
    logic [31:0] ctrl;
    logic [19:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [7:0] vector_reg;
    logic [15:0] handler_off;
    logic [15:0] handler_seg;
    logic vec_valid;
    logic start_pend;
    logic instr_pend;
    logic irq_sync;
    logic ack;
    logic [31:0] wmask;
    logic launch;
    logic take_irq;
    logic take_user;
    logic instr_done;
    logic cycle_done;
    logic busy;
    logic wr_hit;
    logic [31:0] next_readdata;
    clbs_pkg::clbs_cycle_t next_user;

    // interrupt request crosses a synchroniser before any use
    clbs_sync #(
        .WIDTH(1)
    ) u_irq_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(maskable_irq_in),
        .sync_out(irq_sync)
    );

    // T-state divider: one tick per T-state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end
    assign tick = (div_cnt == DIV_LAST);

    // launch decisions only at an idle tick with the bus owned
    assign busy = (tstate != clbs_pkg::TS_IDLE);
    assign launch = tick && !busy && !hold_ack && !hold_req;
    assign instr_done = launch && instr_pend;
    assign take_irq = instr_done && irq_sync && ctrl[clbs_pkg::CTRL_IE];
    assign take_user = launch && start_pend && !take_irq;
    assign cycle_done = tick && (tstate == clbs_pkg::TS_T4);
    assign wr_hit = avs_write && ack;

    // byte lane mask for register writes
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
        {8{avs_byteenable[0]}}};

    // user cycle built from the registers; word or byte select
    always_comb begin
        next_user = '0;
        next_user.addr = addr_reg;
        next_user.wdata = wdata_reg;
        next_user.read = ctrl[clbs_pkg::CTRL_READ];
        next_user.mem = ctrl[clbs_pkg::CTRL_MEM];
        next_user.seg = ctrl[clbs_pkg::CTRL_SEG_LSB +: 2];
        next_user.a0_n = addr_reg[0];
        next_user.bhe_n = ctrl[clbs_pkg::CTRL_BYTE] ? !addr_reg[0] : 1'b0;
        next_user.inta = 1'b0;
    end

    // Avalon answer: waitrequest drops for one cycle after a request is seen
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !ack);
        end
    end

    // read data mux; unmapped offsets read as zero
    always_comb begin
        next_readdata = 32'h00000000;
        case (avs_address)
            clbs_pkg::REG_CTRL: next_readdata = ctrl;
            clbs_pkg::REG_ADDR: next_readdata = {12'h000, addr_reg};
            clbs_pkg::REG_WDATA: next_readdata = {16'h0000, wdata_reg};
            clbs_pkg::REG_STATUS: begin
                next_readdata[clbs_pkg::ST_BUSY] = busy || start_pend;
                next_readdata[clbs_pkg::ST_IRQ] = irq_sync;
                next_readdata[clbs_pkg::ST_INTA] = busy && (stage != clbs_pkg::SQ_USER);
                next_readdata[clbs_pkg::ST_VEC_VALID] = vec_valid;
                next_readdata[clbs_pkg::ST_HOLD] = hold_ack;
                next_readdata[clbs_pkg::ST_TSTATE_LSB +: 3] = tstate;
            end
            clbs_pkg::REG_RDATA: next_readdata = {16'h0000, rdata_reg};
            clbs_pkg::REG_VECTOR: next_readdata = {24'h000000, vector_reg};
            clbs_pkg::REG_HANDLER: next_readdata = {handler_seg, handler_off};
            default: next_readdata = 32'h00000000;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_readdata;
        end
    end

    // control register; hardware clears the enable when it takes an interrupt
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl <= clbs_pkg::CTRL_RESET;
        end else begin
            if (wr_hit && avs_address == clbs_pkg::REG_CTRL) begin
                ctrl <= (ctrl & ~wmask) | (avs_writedata & wmask);
                ctrl[clbs_pkg::CTRL_START] <= 1'b0;
                ctrl[clbs_pkg::CTRL_INSTR_END] <= 1'b0;
            end
            // acknowledge masks further requests until software sets it again
            if (take_irq) begin
                ctrl[clbs_pkg::CTRL_IE] <= 1'b0;
            end
        end
    end

    // address and write data; frozen while a cycle runs so the bus stays stable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_reg <= clbs_pkg::ADDR_RESET;
            wdata_reg <= clbs_pkg::DATA_RESET;
        end else if (wr_hit && !busy) begin
            if (avs_address == clbs_pkg::REG_ADDR) begin
                addr_reg <= (addr_reg & ~wmask[19:0]) | (avs_writedata[19:0] & wmask[19:0]);
            end
            if (avs_address == clbs_pkg::REG_WDATA) begin
                wdata_reg <= (wdata_reg & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
            end
        end
    end

    // pending start and instruction-end requests; a new request beats the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_pend <= 1'b0;
            instr_pend <= 1'b0;
        end else begin
            if (take_user) begin
                start_pend <= 1'b0;
            end
            if (instr_done) begin
                instr_pend <= 1'b0;
            end
            if (wr_hit && avs_address == clbs_pkg::REG_CTRL && avs_byteenable[0]) begin
                if (avs_writedata[clbs_pkg::CTRL_START]) begin
                    start_pend <= 1'b1;
                end
                if (avs_writedata[clbs_pkg::CTRL_INSTR_END]) begin
                    instr_pend <= 1'b1;
                end
            end
        end
    end

    // bus grant to another master, only between cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_ack <= 1'b0;
        end else if (!hold_req) begin
            hold_ack <= 1'b0;
        end else if (tick && !busy) begin
            hold_ack <= 1'b1;
        end
    end

    // T-state machine; ready is used raw, outside logic has synchronised it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tstate <= clbs_pkg::TS_IDLE;
        end else if (tick) begin
            case (tstate)
                clbs_pkg::TS_IDLE: begin
                    if (take_irq || take_user) begin
                        tstate <= clbs_pkg::TS_T1;
                    end
                end
                clbs_pkg::TS_T1: tstate <= clbs_pkg::TS_T2;
                clbs_pkg::TS_T2: tstate <= clbs_pkg::TS_T3;
                // ready low at end of t3 or a wait state holds the cycle
                clbs_pkg::TS_T3, clbs_pkg::TS_WAIT: begin
                    tstate <= ready ? clbs_pkg::TS_T4 : clbs_pkg::TS_WAIT;
                end
                clbs_pkg::TS_T4: begin
                    tstate <= (stage == clbs_pkg::SQ_USER || stage == clbs_pkg::SQ_VEC_SEG) ?
                        clbs_pkg::TS_IDLE : clbs_pkg::TS_T1;
                end
                default: tstate <= clbs_pkg::TS_IDLE;
            endcase
        end
    end

    // stage chain: two acknowledges, then offset and segment from the vector table
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage <= clbs_pkg::SQ_USER;
            cur <= '0;
        end else if (take_user) begin
            stage <= clbs_pkg::SQ_USER;
            cur <= next_user;
        end else if (take_irq) begin
            stage <= clbs_pkg::SQ_INTA1;
            cur <= '0;
            cur.inta <= 1'b1;
            cur.read <= 1'b1;
            cur.bhe_n <= 1'b0;
            cur.a0_n <= 1'b1;
            cur.seg <= clbs_pkg::SEG_CODE_NONE;
        end else if (cycle_done) begin
            case (stage)
                clbs_pkg::SQ_INTA1: begin
                    stage <= clbs_pkg::SQ_INTA2;
                    cur.bhe_n <= 1'b1;
                end
                clbs_pkg::SQ_INTA2: begin
                    stage <= clbs_pkg::SQ_VEC_OFF;
                    cur.inta <= 1'b0;
                    cur.mem <= 1'b1;
                    cur.bhe_n <= 1'b0;
                    cur.a0_n <= 1'b0;
                    cur.seg <= clbs_pkg::SEG_DATA;
                    cur.addr <= 20'(ad_in[7:0]) << clbs_pkg::VEC_ENTRY_SHIFT;
                end
                clbs_pkg::SQ_VEC_OFF: begin
                    stage <= clbs_pkg::SQ_VEC_SEG;
                    cur.addr <= cur.addr + clbs_pkg::VEC_SEG_STEP;
                end
                default: stage <= stage;
            endcase
        end
    end

    // data captured at the end of t4; vector valid set beats software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= clbs_pkg::DATA_RESET;
            vector_reg <= clbs_pkg::VECTOR_RESET;
            handler_off <= clbs_pkg::DATA_RESET;
            handler_seg <= clbs_pkg::DATA_RESET;
            vec_valid <= 1'b0;
        end else begin
            if (wr_hit && avs_address == clbs_pkg::REG_STATUS && avs_byteenable[0] &&
                avs_writedata[clbs_pkg::ST_VEC_VALID]) begin
                vec_valid <= 1'b0;
            end
            if (cycle_done) begin
                case (stage)
                    clbs_pkg::SQ_USER: begin
                        if (cur.read) begin
                            rdata_reg <= ad_in;
                        end
                    end
                    clbs_pkg::SQ_INTA2: vector_reg <= ad_in[7:0];
                    clbs_pkg::SQ_VEC_OFF: handler_off <= ad_in;
                    clbs_pkg::SQ_VEC_SEG: begin
                        handler_seg <= ad_in;
                        vec_valid <= 1'b1;
                    end
                    default: rdata_reg <= rdata_reg;
                endcase
            end
        end
    end

    // multiplexed address/data lines: address in t1 except in acknowledges, data after; floats for reads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ad_out <= 16'h0000;
            ad_oe_n <= 1'b1;
            low_byte_select_n <= 1'b1;
        end else begin
            ad_oe_n <= 1'b1;
            if (tstate == clbs_pkg::TS_T1) begin
                ad_out <= {cur.addr[15:1], cur.a0_n};
                ad_oe_n <= hold_ack || cur.inta;
                low_byte_select_n <= cur.a0_n;
            end else if (busy) begin
                ad_out <= cur.wdata;
                ad_oe_n <= cur.read || hold_ack;
                low_byte_select_n <= 1'b1;
            end else begin
                low_byte_select_n <= 1'b1;
            end
        end
    end

    // upper address in t1, then status: S6 low, S5 interrupt enable, segment code
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_hi_status <= 2'h0;
            segment_status_hi <= 1'b0;
            segment_status_lo <= 1'b0;
            status_oe_n <= 1'b0;
        end else begin
            status_oe_n <= hold_ack;
            if (tstate == clbs_pkg::TS_T1) begin
                addr_hi_status <= cur.mem ? cur.addr[19:18] : 2'h0;
                segment_status_hi <= cur.mem && cur.addr[17];
                segment_status_lo <= cur.mem && cur.addr[16];
            end else if (busy) begin
                addr_hi_status <= {1'b0, ctrl[clbs_pkg::CTRL_IE]};
                segment_status_hi <= cur.seg[1];
                segment_status_lo <= cur.seg[0];
            end
        end
    end

    // high-byte enable valid in t1 only; low in t1 of first acknowledge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            high_byte_enable_n <= 1'b1;
            mem_io <= 1'b1;
            ale <= 1'b0;
        end else begin
            high_byte_enable_n <= (tstate == clbs_pkg::TS_T1) ? cur.bhe_n : 1'b1;
            ale <= (tstate == clbs_pkg::TS_T1) && (div_cnt != '0) && !hold_ack;
            // memory-versus-I/O status beside the strobes; floats high in hold
            mem_io <= (busy && !hold_ack) ? cur.mem : 1'b1;
        end
    end

    // read strobe: low only after the first half of t2 when drivers are off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            read_n <= 1'b1;
            read_oe_n <= 1'b0;
            inta_n <= 1'b1;
        end else begin
            read_n <= !(cur.read && !cur.inta && !hold_ack && ((tstate == clbs_pkg::TS_T2 &&
                div_cnt != '0) || tstate == clbs_pkg::TS_T3 || tstate == clbs_pkg::TS_WAIT));
            read_oe_n <= hold_ack;
            inta_n <= !(cur.inta && ((tstate == clbs_pkg::TS_T2 && div_cnt != '0) ||
                tstate == clbs_pkg::TS_T3 || tstate == clbs_pkg::TS_WAIT));
        end
    end
endmodule

/* File: verification/clbs_properties.sv */
// port-level checks for the local bus strobe unit
`timescale 1ns/1ns
module clbs_properties #(
    parameter int TSTATE_CLKS = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic ad_oe_n,
    input wire logic status_oe_n,
    input wire logic read_n,
    input wire logic read_oe_n,
    input wire logic inta_n,
    input wire logic ale,
    input wire logic ready,
    input wire logic hold_ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // strobe drop, then low for the t2 tail and all of t3
    sequence s_fall; $fell(read_n); endsequence
    sequence s_low3; !read_n [*3]; endsequence
    sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
    property p_len; s_fall |-> s_low3; endproperty
    property p_rel; s_fall |-> ad_oe_n && $past(ad_oe_n); endproperty
    property p_float; read_oe_n |-> read_n; endproperty
    property p_hold; hold_ack && $past(hold_ack) |-> read_oe_n && ad_oe_n && status_oe_n; endproperty
    property p_quiet; ale |-> read_n && inta_n; endproperty
    property p_inta; !inta_n |-> read_n && ad_oe_n; endproperty
    // a strobe may only end once ready was seen high, two clocks before the pin rises
    property p_ready; $rose(read_n) && !read_oe_n |-> $past(ready, 2); endproperty
    property p_avs; s_req |=> !avs_waitrequest; endproperty
    a_len: assert property (p_len) else $error("read strobe too short");
    a_rel: assert property (p_rel) else $error("strobe while bus driven");
    a_float: assert property (p_float) else $error("floated strobe not high");
    a_hold: assert property (p_hold) else $error("outputs driven in hold");
    a_quiet: assert property (p_quiet) else $error("strobe active in t1");
    a_inta: assert property (p_inta) else $error("read strobe in acknowledge");
    a_ready: assert property (p_ready) else $error("cycle ended without ready");
    a_avs: assert property (p_avs) else $error("slave answer late");
endmodule

bind clbs_bus_unit clbs_properties #(.TSTATE_CLKS(TSTATE_CLKS)) chk_u (.clk, .rst_n, .avs_read, .avs_write,
    .avs_waitrequest, .ad_oe_n, .status_oe_n, .read_n, .read_oe_n, .inta_n, .ale, .ready, .hold_ack);

/* File: verification/clbs_mem_model.sv */
// memory and I/O model on the far side of the local bus
`timescale 1ns/1ns
module clbs_mem_model #(
    parameter logic [15:0] VEC = 16'h0021
) (
    input wire logic clk,
    input wire logic [15:0] ad_out,
    input wire logic ad_oe_n,
    input wire logic ale,
    input wire logic read_n,
    input wire logic inta_n,
    input wire logic [3:0] wait_cnt,
    output logic [15:0] ad_in,
    output logic ready
);
    logic [15:0] addr = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [7:0] cnt = 8'hFF;
    logic [1:0] hc = 2'h0;
    logic ia = 1'b0;
    // latch address in t1, count clocks, keep data a short hold after the strobe
    always @(posedge clk) begin
        if (ale) begin
            addr <= ad_out;
            cnt <= 8'h00;
        end else if (cnt != 8'hFF) begin
            cnt <= cnt + 8'h01;
        end
        hc <= (!read_n || !inta_n) ? 2'h3 : (hc != 2'h0 ? hc - 2'h1 : 2'h0);
        // remember which strobe ran, so the hold time after it keeps the right data
        if (!read_n || !inta_n) ia <= !inta_n;
        last <= ad_in;
    end
    // ready is clock-aligned here, held until the next t1 or until the count saturates at 8'hFF
    // threshold gives exactly wait_cnt wait states at the end of t3
    assign ready = cnt >= 8'(2 + 2 * wait_cnt) && cnt != 8'hFF;
    // an undriven bus shows a changing pattern, never the old value
    assign ad_in = (ad_oe_n && (!read_n || !inta_n || hc != 2'h0)) ? (ia ? VEC : addr ^ 16'h5A5A) : ~last;
endmodule

/* File: verification/cpu_local_bus_strobes_test.sv */
// self-checking bench for the local bus strobe unit
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module cpu_local_bus_strobes_test;
    typedef struct packed {logic [15:0] a; logic b; logic m; logic [1:0] s; logic [3:0] w; logic [1:0] sel;} clbs_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata, rdat;
    logic avs_waitrequest, ad_oe_n, status_oe_n, high_byte_enable_n, low_byte_select_n, read_n, read_oe_n;
    logic segment_status_hi, segment_status_lo, inta_n, mem_io, ale, ready, hold_ack, rd_q, inta_q, mio;
    logic maskable_irq_in = 1'b0;
    logic hold_req = 1'b0;
    logic [3:0] wait_cnt = 4'h0;
    logic [15:0] ad_in, ad_out;
    logic [1:0] addr_hi_status, sel, inta_sel;
    logic [3:0] seg;
    int failures = 0;
    int n_tests = 0;
    int n_inta = 0;
    int lowc = 0;
    clbs_row_t rows [4] = '{
        '{16'h1234, 1'b0, 1'b1, 2'h0, 4'h0, 2'h0},
        '{16'h1235, 1'b1, 1'b1, 2'h1, 4'h2, 2'h1},
        '{16'h2002, 1'b1, 1'b0, 2'h2, 4'h0, 2'h2},
        '{16'h7FFE, 1'b0, 1'b0, 2'h3, 4'h5, 2'h0}
    };
    clbs_bus_unit dut_u (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
        .avs_readdata, .avs_waitrequest, .ad_in, .ad_out, .ad_oe_n, .addr_hi_status, .segment_status_hi,
        .segment_status_lo, .status_oe_n, .high_byte_enable_n, .low_byte_select_n, .read_n, .read_oe_n, .inta_n,
        .mem_io, .ale, .ready, .maskable_irq_in, .hold_req, .hold_ack);
    clbs_mem_model mem_u (.clk, .ad_out, .ad_oe_n, .ale, .read_n, .inta_n, .wait_cnt, .ad_in, .ready);
    initial begin
        forever #4 clk = ~clk;
    end
    // snapshots: byte selects at t1, segment and space once the strobe drops
    always @(posedge clk) begin
        if (ale) sel <= {high_byte_enable_n, low_byte_select_n};
        if (!read_n && rd_q) seg <= {addr_hi_status, segment_status_hi, segment_status_lo};
        if (!read_n) lowc <= rd_q ? 1 : lowc + 1;
        if (!read_n && rd_q) mio <= mem_io;
        if (!inta_n && inta_q && n_inta == 0) inta_sel <= sel;
        if (!inta_n && inta_q) n_inta <= n_inta + 1;
        rd_q <= read_n;
        inta_q <= inta_n;
    end
    task automatic print_verdict();
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one slave access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        for (i = 0; i < 50 && avs_waitrequest !== 1'b0; i++) @(posedge clk);
        if (i == 50) begin failures++; print_verdict(); end
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input int b, input logic v);
        int k;
        for (k = 0; k < 200; k++) begin
            bus(1'b0, clbs_pkg::REG_STATUS, 32'h0);
            if (rdat[b] === v) break;
        end
        if (k == 200) begin failures++; print_verdict(); end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // outputs still at their reset values
        `CHK({avs_waitrequest, read_n, read_oe_n, inta_n, hold_ack, ale, high_byte_enable_n, low_byte_select_n, mem_io, ad_oe_n, status_oe_n}, 11'h69E)
        // ordinary reads, word and byte lanes, both spaces, with and without waits
        for (int i = 0; i < 4; i++) begin
            wait_cnt <= rows[i].w;
            bus(1'b1, clbs_pkg::REG_ADDR, {16'h0, rows[i].a});
            bus(1'b1, clbs_pkg::REG_CTRL, {26'h0, rows[i].s, rows[i].b, rows[i].m, 2'b11});
            poll(clbs_pkg::ST_BUSY, 1'b1);
            poll(clbs_pkg::ST_BUSY, 1'b0);
            `CHK(sel, rows[i].sel)
            `CHK(seg, {2'h0, rows[i].s})
            `CHK(lowc, 1 + clbs_pkg::TSTATE_CLKS * (1 + rows[i].w))
            `CHK(mio, rows[i].m)
            bus(1'b0, clbs_pkg::REG_RDATA, 32'h0);
            if (!rows[i].b) `CHK(rdat[15:0], rows[i].a ^ 16'h5A5A)
        end
        // unmapped place reads zero after a dropped write
        bus(1'b1, 5'h1C, 32'hFFFFFFFF);
        bus(1'b0, 5'h1C, 32'h0);
        `CHK(rdat, 32'h00000000)
        // request ignored while disabled, then taken
        maskable_irq_in <= 1'b1;
        bus(1'b1, clbs_pkg::REG_CTRL, 32'h00000080);
        repeat (40) @(posedge clk);
        `CHK(n_inta, 0)
        bus(1'b1, clbs_pkg::REG_CTRL, 32'h000000C0);
        poll(clbs_pkg::ST_VEC_VALID, 1'b1);
        maskable_irq_in <= 1'b0;
        `CHK(n_inta, 2)
        `CHK(inta_sel[1], 1'b0)
        bus(1'b0, clbs_pkg::REG_HANDLER, 32'h0);
        `CHK(rdat, 32'h5ADC5ADE)
        // another master takes the bus
        hold_req <= 1'b1;
        poll(clbs_pkg::ST_HOLD, 1'b1);
        `CHK({read_oe_n, read_n, ad_oe_n}, 3'b111)
        hold_req <= 1'b0;
        poll(clbs_pkg::ST_HOLD, 1'b0);
        print_verdict();
    end
endmodule
